// ---- verilog/txmi_assembler.sv ----
// Functional notes
// [RULE_01] With the select bit clear, bit 13 flags bus activity right after the transmit command.
// [RULE_02] With the select bit set, bit 13 instead flags a broadcast message.
// [RULE_03] Bit 12 flags data words arriving with the transmit command.
// [RULE_04] Bit 10 is set whenever the bit 12 or bit 13 error condition arose.
// [RULE_05] Bit 9 flags a busy answer, and then no data words are sent.
// [RULE_06] Busy comes from the global busy bit or the per-command busy bit.
// [RULE_07] Bit 8 is set when the illegalization entry for the command is one.
// [RULE_08] The host keeps the illegalization table zero unless it wants illegal detection.
// [RULE_09] Bit 6 flags an RT-to-RT transfer that finished without error.
// [RULE_10] Bit 5 gives the bus, zero for A and one for B.
// [RULE_11] Bits 4 to 0 carry the command word count, zero meaning thirty-two.
// [RULE_12] The info word goes to the first reserved word and the time tag to the next.
// [RULE_13] The data pointer addresses the info word, not the first data word.
// [RULE_14] Bits 15, 14, 11 and 7 of the word are written as zero.
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module txmi_assembler (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic msg_start,
    input wire logic msg_end,
    input wire logic [15:0] cmd_word,
    input wire logic bus_identifier,
    input wire logic cmd_broadcast,
    input wire logic per_command_busy,
    input wire logic illegal_entry,
    input wire logic terminal_to_terminal,
    input wire logic terminal_to_terminal_flag_error,
    input wire logic gap_activity,
    input wire logic extra_data,
    input wire logic [14:0] data_ptr,
    input wire logic [15:0] time_tag,
    output logic [15:0] reg_rdata_q,
    output logic irq_q,
    output logic [14:0] ram_addr_q,
    output logic [15:0] ram_wdata_q,
    output logic ram_we_q,
    output logic resp_busy_q,
    output logic data_tx_en_q
);
    txmi_pkg::txmi_state_t state_q, state_d;
    logic [15:0] cfg_q, cfg_d;
    logic [15:0] stat_q, stat_d;
    logic [15:0] reg_rdata_d;
    logic [15:0] info_q, info_d;
    logic [15:0] tag_q, tag_d;
    logic [14:0] ptr_q, ptr_d;
    logic [4:0] wcount_q, wcount_d;
    logic gap_q, gap_d;
    logic wcerr_q, wcerr_d;
    logic bcast_q, bcast_d;
    logic bus_q, bus_d;
    logic illegal_q, illegal_d;
    logic terminal_to_terminal_flag_q, terminal_to_terminal_flag_d;
    logic terminal_to_terminal_flag_err_q, terminal_to_terminal_flag_err_d;
    logic resp_busy_d;
    logic data_tx_en_d;
    logic wr_go_q, wr_go_d;
    logic wr_busy;
    logic [3:0] int_status;
    logic [3:0] int_mask;
    logic [3:0] int_events;
    logic int_clr_wr;
    logic int_mask_wr;

    // Software registers written from the register port
    always_comb begin
        cfg_d = cfg_q;
        stat_d = stat_q;
        if (reg_wr && reg_addr == txmi_pkg::ADDR_CFG) begin
            cfg_d = reg_wdata;
        end
        if (reg_wr && reg_addr == txmi_pkg::ADDR_STAT_BITS) begin
            stat_d = reg_wdata;
        end
    end

    // Read data one cycle after the strobe, unmapped reads zero
    always_comb begin
        reg_rdata_d = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                txmi_pkg::ADDR_CFG: reg_rdata_d = cfg_q;
                txmi_pkg::ADDR_STAT_BITS: reg_rdata_d = stat_q;
                txmi_pkg::ADDR_INT_STATUS: reg_rdata_d = {12'h000, int_status};
                txmi_pkg::ADDR_INT_MASK: reg_rdata_d = {12'h000, int_mask};
                txmi_pkg::ADDR_LAST_WORD: reg_rdata_d = info_q;
                default: reg_rdata_d = 16'h0000;
            endcase
        end
    end

    // Register port flops
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg_q <= txmi_pkg::CFG_RESET;
            stat_q <= txmi_pkg::STAT_RESET;
            reg_rdata_q <= 16'h0000;
        end else begin
            cfg_q <= cfg_d;
            stat_q <= stat_d;
            reg_rdata_q <= reg_rdata_d;
        end
    end

    // Message sequence and flag collection
    always_comb begin
        state_d = state_q;
        info_d = info_q;
        tag_d = tag_q;
        ptr_d = ptr_q;
        wcount_d = wcount_q;
        gap_d = gap_q;
        wcerr_d = wcerr_q;
        bcast_d = bcast_q;
        bus_d = bus_q;
        illegal_d = illegal_q;
        terminal_to_terminal_flag_d = terminal_to_terminal_flag_q;
        terminal_to_terminal_flag_err_d = terminal_to_terminal_flag_err_q;
        resp_busy_d = resp_busy_q;
        data_tx_en_d = 1'b0;
        wr_go_d = 1'b0;
        unique case (state_q)
            txmi_pkg::TXMI_IDLE: begin
                if (msg_start) begin
                    state_d = txmi_pkg::TXMI_ACTIVE;
                    ptr_d = data_ptr; // RULE_13
                    wcount_d = cmd_word[4:0]; // RULE_11
                    bcast_d = cmd_broadcast; // RULE_02
                    bus_d = bus_identifier; // RULE_10
                    illegal_d = illegal_entry; // RULE_07
                    terminal_to_terminal_flag_d = terminal_to_terminal;
                    terminal_to_terminal_flag_err_d = 1'b0;
                    gap_d = 1'b0;
                    wcerr_d = 1'b0;
                    resp_busy_d = stat_q[txmi_pkg::STAT_GLOBAL_BUSY] | per_command_busy; // RULE_06
                    data_tx_en_d = ~resp_busy_d; // RULE_05
                end
            end
            txmi_pkg::TXMI_ACTIVE: begin
                data_tx_en_d = ~resp_busy_q; // RULE_05
                gap_d = gap_q | gap_activity; // RULE_01
                wcerr_d = wcerr_q | extra_data; // RULE_03
                terminal_to_terminal_flag_err_d = terminal_to_terminal_flag_err_q | terminal_to_terminal_flag_error; // RULE_09
                if (msg_end) begin
                    state_d = txmi_pkg::TXMI_WAIT;
                    data_tx_en_d = 1'b0;
                    info_d = txmi_pkg::txmi_pack(cfg_q[txmi_pkg::CFG_BCAST_SEL], gap_d, bcast_q,
                        wcerr_d, resp_busy_q, illegal_q, terminal_to_terminal_flag_q & ~terminal_to_terminal_flag_err_d, bus_q, wcount_q); // RULE_04
                    tag_d = time_tag;
                    wr_go_d = 1'b1; // RULE_12
                end
            end
            txmi_pkg::TXMI_WAIT: begin
                resp_busy_d = 1'b0;
                if (!wr_go_q && !wr_busy) begin
                    state_d = txmi_pkg::TXMI_IDLE;
                end
            end
        endcase
    end

    // Message state flops
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= txmi_pkg::TXMI_IDLE;
            info_q <= 16'h0000;
            tag_q <= 16'h0000;
            ptr_q <= 15'h0000;
            wcount_q <= 5'h00;
            gap_q <= 1'b0;
            wcerr_q <= 1'b0;
            bcast_q <= 1'b0;
            bus_q <= 1'b0;
            illegal_q <= 1'b0;
            terminal_to_terminal_flag_q <= 1'b0;
            terminal_to_terminal_flag_err_q <= 1'b0;
            resp_busy_q <= 1'b0;
            data_tx_en_q <= 1'b0;
            wr_go_q <= 1'b0;
        end else begin
            state_q <= state_d;
            info_q <= info_d;
            tag_q <= tag_d;
            ptr_q <= ptr_d;
            wcount_q <= wcount_d;
            gap_q <= gap_d;
            wcerr_q <= wcerr_d;
            bcast_q <= bcast_d;
            bus_q <= bus_d;
            illegal_q <= illegal_d;
            terminal_to_terminal_flag_q <= terminal_to_terminal_flag_d;
            terminal_to_terminal_flag_err_q <= terminal_to_terminal_flag_err_d;
            resp_busy_q <= resp_busy_d;
            data_tx_en_q <= data_tx_en_d;
            wr_go_q <= wr_go_d;
        end
    end

    // Shared RAM writes of info word and time tag
    txmi_ram_writer u_writer (
        .ref_clk(ref_clk),
        .rst(rst),
        .go(wr_go_q),
        .base_ptr(ptr_q),
        .info_word(info_q),
        .tag_word(tag_q),
        .ram_addr_q(ram_addr_q),
        .ram_wdata_q(ram_wdata_q),
        .ram_we_q(ram_we_q),
        .busy(wr_busy)
    );

    // Interrupt events raised when the word is launched
    always_comb begin
        int_events = 4'h0;
        int_events[txmi_pkg::INT_DONE] = wr_go_q;
        int_events[txmi_pkg::INT_MSG_ERR] = wr_go_q & info_q[txmi_pkg::MI_MSG_ERR];
        int_events[txmi_pkg::INT_BUSY] = wr_go_q & info_q[txmi_pkg::MI_BUSY];
        int_events[txmi_pkg::INT_ILLEGAL] = wr_go_q & info_q[txmi_pkg::MI_ILLEGAL];
        int_clr_wr = reg_wr && reg_addr == txmi_pkg::ADDR_INT_STATUS;
        int_mask_wr = reg_wr && reg_addr == txmi_pkg::ADDR_INT_MASK;
    end

    txmi_int_ctrl u_int (
        .ref_clk(ref_clk),
        .rst(rst),
        .events(int_events),
        .clr_wr(int_clr_wr),
        .mask_wr(int_mask_wr),
        .wdata(reg_wdata[3:0]),
        .status_q(int_status),
        .mask_q(int_mask),
        .irq_q(irq_q)
    );

    // Checks on the assembled word and its delivery
    sequence s_info_write;
        ram_we_q && ram_addr_q == ptr_q && ram_wdata_q == info_q;
    endsequence

    sequence s_tag_write;
        ram_we_q && ram_addr_q == 15'(ptr_q + 15'h0001) && ram_wdata_q == tag_q;
    endsequence

    a_gap_flag_mode: assert property (@(posedge ref_clk) disable iff (rst) // RULE_01
        wr_go_q && !cfg_q[txmi_pkg::CFG_BCAST_SEL] |-> info_q[txmi_pkg::MI_GAP_OR_BROADCAST_FLAG] == gap_q)
        else $error("gap flag does not follow bus activity");

    a_bcast_flag_mode: assert property (@(posedge ref_clk) disable iff (rst) // RULE_02
        wr_go_q && cfg_q[txmi_pkg::CFG_BCAST_SEL] |-> info_q[txmi_pkg::MI_GAP_OR_BROADCAST_FLAG] == bcast_q)
        else $error("broadcast flag wrong");

    a_wcount_error: assert property (@(posedge ref_clk) disable iff (rst) // RULE_03
        state_q == txmi_pkg::TXMI_ACTIVE && msg_end && (wcerr_q || extra_data) |=> info_q[txmi_pkg::MI_WC_ERR])
        else $error("extra data words not flagged");

    a_msg_error_flag: assert property (@(posedge ref_clk) disable iff (rst) // RULE_04
        wr_go_q |-> info_q[txmi_pkg::MI_MSG_ERR] == (info_q[txmi_pkg::MI_WC_ERR] | gap_q))
        else $error("message error flag mismatch");

    a_busy_no_data: assert property (@(posedge ref_clk) disable iff (rst) // RULE_05
        resp_busy_q |-> !data_tx_en_q)
        else $error("data sent with busy answer");

    a_busy_source: assert property (@(posedge ref_clk) disable iff (rst) // RULE_06
        state_q == txmi_pkg::TXMI_IDLE && msg_start |=>
        resp_busy_q == ($past(stat_q[txmi_pkg::STAT_GLOBAL_BUSY]) | $past(per_command_busy)))
        else $error("busy answer source wrong");

    a_illegal_flag: assert property (@(posedge ref_clk) disable iff (rst) // RULE_07
        wr_go_q |-> info_q[txmi_pkg::MI_ILLEGAL] == illegal_q)
        else $error("illegal flag lost");

    a_illegal_capture: assert property (@(posedge ref_clk) disable iff (rst) // RULE_07
        state_q == txmi_pkg::TXMI_IDLE && msg_start |=> illegal_q == $past(illegal_entry))
        else $error("illegal entry not captured");

    a_terminal_to_terminal_flag_flag: assert property (@(posedge ref_clk) disable iff (rst) // RULE_09
        wr_go_q && info_q[txmi_pkg::MI_TERMINAL_TO_TERMINAL_FLAG] |-> terminal_to_terminal_flag_q && !terminal_to_terminal_flag_err_q && !info_q[txmi_pkg::MI_MSG_ERR])
        else $error("rt-rt flag set on failed transfer");

    a_bus_and_count: assert property (@(posedge ref_clk) disable iff (rst) // RULE_10
        wr_go_q |-> info_q[txmi_pkg::MI_BUS] == bus_q && info_q[txmi_pkg::MI_WC_HI:0] == wcount_q)
        else $error("bus or word count field wrong");

    a_count_capture: assert property (@(posedge ref_clk) disable iff (rst) // RULE_11
        state_q == txmi_pkg::TXMI_IDLE && msg_start |=> wcount_q == $past(cmd_word[4:0]))
        else $error("word count not taken from command");

    a_write_order: assert property (@(posedge ref_clk) disable iff (rst) // RULE_12
        wr_go_q |=> s_info_write ##1 s_tag_write ##1 !ram_we_q)
        else $error("info and tag words not written in order");

    a_ptr_base: assert property (@(posedge ref_clk) disable iff (rst) // RULE_13
        wr_go_q |=> ram_addr_q == ptr_q)
        else $error("info word not at data pointer");

    a_unused_zero: assert property (@(posedge ref_clk) disable iff (rst) // RULE_14
        wr_go_q |=> (ram_wdata_q & txmi_pkg::MI_UNUSED_MASK) == 16'h0000)
        else $error("unused bits not zero");

endmodule : txmi_assembler
`default_nettype wire

// ---- inc/txmi_pkg.sv ----
package txmi_pkg;
    // Register addresses on the plain register port
    localparam logic [3:0] ADDR_CFG = 4'h1;
    localparam logic [3:0] ADDR_STAT_BITS = 4'h2;
    localparam logic [3:0] ADDR_INT_STATUS = 4'h3;
    localparam logic [3:0] ADDR_INT_MASK = 4'h4;
    localparam logic [3:0] ADDR_LAST_WORD = 4'h5;
    // Configuration and status bit positions
    localparam int CFG_BCAST_SEL = 3;
    localparam int STAT_GLOBAL_BUSY = 0;
    // Reset values
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] STAT_RESET = 16'h0000;
    localparam logic [3:0] INT_RESET = 4'h0;
    // Interrupt event bit positions
    localparam int INT_DONE = 0;
    localparam int INT_MSG_ERR = 1;
    localparam int INT_BUSY = 2;
    localparam int INT_ILLEGAL = 3;
    localparam int INT_WIDTH = 4;
    // Message information word field positions
    localparam int MI_GAP_OR_BROADCAST_FLAG = 13;
    localparam int MI_WC_ERR = 12;
    localparam int MI_MSG_ERR = 10;
    localparam int MI_BUSY = 9;
    localparam int MI_ILLEGAL = 8;
    localparam int MI_TERMINAL_TO_TERMINAL_FLAG = 6;
    localparam int MI_BUS = 5;
    localparam int MI_WC_HI = 4;
    localparam logic [15:0] MI_UNUSED_MASK = 16'hc880;
    localparam int PTR_WIDTH = 15;

    typedef enum logic [1:0] {TXMI_IDLE, TXMI_ACTIVE, TXMI_WAIT} txmi_state_t;
    typedef enum logic {TXMI_WR_IDLE, TXMI_WR_TAG} txmi_wr_state_t;

    // Packs the transmit message information word
    function automatic logic [15:0] txmi_pack(
        input logic bcast_sel,
        input logic gap,
        input logic bcast,
        input logic wc_err,
        input logic busy,
        input logic illegal,
        input logic terminal_to_terminal_flag_ok,
        input logic bus_b,
        input logic [4:0] wcount
    );
        logic [15:0] w;
        w = 16'h0000; // RULE_14
        w[MI_GAP_OR_BROADCAST_FLAG] = bcast_sel ? bcast : gap;
        w[MI_WC_ERR] = wc_err;
        w[MI_MSG_ERR] = wc_err | gap;
        w[MI_BUSY] = busy;
        w[MI_ILLEGAL] = illegal;
        w[MI_TERMINAL_TO_TERMINAL_FLAG] = terminal_to_terminal_flag_ok & ~(wc_err | gap);
        w[MI_BUS] = bus_b;
        w[MI_WC_HI:0] = wcount;
        return w;
    endfunction : txmi_pack
endpackage : txmi_pkg

// ---- verilog/txmi_ram_writer.sv ----
`timescale 1ns/10ps
`default_nettype none
module txmi_ram_writer (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [14:0] base_ptr,
    input wire logic [15:0] info_word,
    input wire logic [15:0] tag_word,
    output logic [14:0] ram_addr_q,
    output logic [15:0] ram_wdata_q,
    output logic ram_we_q,
    output logic busy
);
    txmi_pkg::txmi_wr_state_t state_q, state_d;
    logic [14:0] ram_addr_d;
    logic [15:0] ram_wdata_d;
    logic ram_we_d;

    // Info word at the pointer, time tag one location above
    always_comb begin
        state_d = state_q;
        ram_addr_d = ram_addr_q;
        ram_wdata_d = ram_wdata_q;
        ram_we_d = 1'b0;
        unique case (state_q)
            txmi_pkg::TXMI_WR_IDLE: begin
                if (go) begin
                    ram_addr_d = base_ptr; // RULE_13
                    ram_wdata_d = info_word;
                    ram_we_d = 1'b1;
                    state_d = txmi_pkg::TXMI_WR_TAG;
                end
            end
            txmi_pkg::TXMI_WR_TAG: begin
                ram_addr_d = 15'(base_ptr + 15'h0001); // RULE_12
                ram_wdata_d = tag_word;
                ram_we_d = 1'b1;
                state_d = txmi_pkg::TXMI_WR_IDLE;
            end
        endcase
    end

    // State and write port registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= txmi_pkg::TXMI_WR_IDLE;
            ram_addr_q <= 15'h0000;
            ram_wdata_q <= 16'h0000;
            ram_we_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ram_addr_q <= ram_addr_d;
            ram_wdata_q <= ram_wdata_d;
            ram_we_q <= ram_we_d;
        end
    end

    assign busy = (state_q != txmi_pkg::TXMI_WR_IDLE);
endmodule : txmi_ram_writer
`default_nettype wire

// ---- verilog/txmi_int_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
module txmi_int_ctrl (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] events,
    input wire logic clr_wr,
    input wire logic mask_wr,
    input wire logic [3:0] wdata,
    output logic [3:0] status_q,
    output logic [3:0] mask_q,
    output logic irq_q
);
    logic [3:0] status_d;
    logic [3:0] mask_d;
    logic irq_d;

    // Sticky status, write one to clear, a new event wins
    always_comb begin
        status_d = status_q;
        if (clr_wr) begin
            status_d = status_q & ~wdata;
        end
        status_d = status_d | events;
        mask_d = mask_wr ? wdata : mask_q;
        irq_d = |(status_d & mask_d);
    end

    // Status, mask and interrupt line
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_q <= txmi_pkg::INT_RESET;
            mask_q <= txmi_pkg::INT_RESET;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
        end
    end
endmodule : txmi_int_ctrl
`default_nettype wire

// ---- tb/txmi_bc_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module txmi_bc_model (
    input wire logic ref_clk,
    input wire logic [14:0] ram_addr_q,
    input wire logic [15:0] ram_wdata_q,
    input wire logic ram_we_q,
    input wire logic resp_busy_q,
    input wire logic data_tx_en_q,
    output logic msg_start,
    output logic msg_end,
    output logic [15:0] cmd_word,
    output logic bus_identifier,
    output logic cmd_broadcast,
    output logic per_command_busy,
    output logic illegal_entry,
    output logic terminal_to_terminal,
    output logic terminal_to_terminal_flag_error,
    output logic gap_activity,
    output logic extra_data,
    output logic [14:0] data_ptr,
    output logic [15:0] time_tag
);
    logic [15:0] mem [0:32767];
    int wr_cnt = 0;
    logic seen_busy;
    logic seen_txen;

    // Quiet link at time zero
    initial begin
        {msg_start, msg_end, terminal_to_terminal_flag_error, gap_activity, extra_data} = 5'h00;
        {bus_identifier, cmd_broadcast, per_command_busy, illegal_entry, terminal_to_terminal} = 5'h00;
        cmd_word = 16'h0000;
        data_ptr = 15'h0000;
        time_tag = 16'h0000;
    end

    // Shared RAM seen by the host
    always @(posedge ref_clk) begin
        if (ram_we_q === 1'b1) begin
            mem[ram_addr_q] = ram_wdata_q;
            wr_cnt = wr_cnt + 1;
        end
    end

    // One transmit message, then the minimum idle spacing
    task automatic send(input logic [4:0] wc, input logic bus, bc, mkb, ill, terminal_to_terminal_flag, rerr, gap, ext,
                        input logic [14:0] ptr, input logic [15:0] tag);
        @(posedge ref_clk);
        msg_start <= 1'b1;
        cmd_word <= {11'h421, wc};
        {bus_identifier, cmd_broadcast, per_command_busy, illegal_entry, terminal_to_terminal} <=
            {bus, bc, mkb, ill, terminal_to_terminal_flag};
        data_ptr <= ptr;
        @(posedge ref_clk);
        msg_start <= 1'b0;
        // Released fields no longer hold their value
        cmd_word <= ~cmd_word;
        {bus_identifier, cmd_broadcast, per_command_busy, illegal_entry, terminal_to_terminal} <=
            ~{bus, bc, mkb, ill, terminal_to_terminal_flag};
        data_ptr <= ~ptr;
        terminal_to_terminal_flag_error <= rerr;
        extra_data <= ext;
        @(posedge ref_clk);
        seen_busy = resp_busy_q;
        seen_txen = data_tx_en_q;
        terminal_to_terminal_flag_error <= 1'b0;
        extra_data <= 1'b0;
        @(posedge ref_clk);
        msg_end <= 1'b1;
        gap_activity <= gap;
        time_tag <= tag;
        @(posedge ref_clk);
        msg_end <= 1'b0;
        gap_activity <= 1'b0;
        time_tag <= ~tag;
        repeat (5) @(posedge ref_clk);
    endtask : send
endmodule : txmi_bc_model
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic msg_start, msg_end, terminal_to_terminal_flag_error, gap_activity, extra_data;
    logic bus_identifier, cmd_broadcast, per_command_busy, illegal_entry, terminal_to_terminal;
    logic [15:0] cmd_word, time_tag, reg_rdata_q, ram_wdata_q, rd;
    logic [14:0] data_ptr, ram_addr_q;
    logic irq_q, ram_we_q, resp_busy_q, data_tx_en_q, mask_on;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;

    // 40 MHz clock
    always #12.5 ref_clk = ~ref_clk;

    txmi_assembler i_txmi_assembler (
        .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .msg_start, .msg_end, .cmd_word,
        .bus_identifier, .cmd_broadcast, .per_command_busy, .illegal_entry, .terminal_to_terminal,
        .terminal_to_terminal_flag_error, .gap_activity, .extra_data, .data_ptr, .time_tag, .reg_rdata_q, .irq_q,
        .ram_addr_q, .ram_wdata_q, .ram_we_q, .resp_busy_q, .data_tx_en_q
    );

    txmi_bc_model u_bc (
        .ref_clk, .ram_addr_q, .ram_wdata_q, .ram_we_q, .resp_busy_q, .data_tx_en_q, .msg_start,
        .msg_end, .cmd_word, .bus_identifier, .cmd_broadcast, .per_command_busy, .illegal_entry,
        .terminal_to_terminal, .terminal_to_terminal_flag_error, .gap_activity, .extra_data, .data_ptr, .time_tag
    );

    task automatic tally_and_finish();
        if (miscompares == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic chk_w(input logic [15:0] got, exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask : chk_w

    task automatic chk_b(input logic got, exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask : chk_b

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        d = reg_rdata_q;
    endtask : reg_read

    // Expected information word
    function automatic logic [15:0] exp_info(input logic sel, bc, gap, ext, busy, ill, terminal_to_terminal_flag, rerr, bus,
                                             input logic [4:0] wc);
        logic [15:0] e;
        e = 16'h0000;
        e[13] = sel ? bc : gap;
        e[12] = ext;
        e[10] = ext | gap;
        e[9] = busy;
        e[8] = ill;
        e[6] = terminal_to_terminal_flag & ~rerr & ~(ext | gap);
        e[5] = bus;
        e[4:0] = wc;
        return e;
    endfunction : exp_info

    task automatic run_msg(input logic sel, gb, input logic [4:0] wc, input logic bus, bc, mkb, ill, terminal_to_terminal_flag,
                           rerr, gap, ext, input logic [14:0] ptr, input logic [15:0] tag);
        logic [15:0] e;
        int w0;
        e = exp_info(sel, bc, gap, ext, gb | mkb, ill, terminal_to_terminal_flag, rerr, bus, wc);
        reg_write(txmi_pkg::ADDR_CFG, {12'h000, sel, 3'h0});
        reg_write(txmi_pkg::ADDR_STAT_BITS, {15'h0000, gb});
        w0 = u_bc.wr_cnt;
        u_bc.send(wc, bus, bc, mkb, ill, terminal_to_terminal_flag, rerr, gap, ext, ptr, tag);
        chk_b(u_bc.seen_busy, gb | mkb);
        chk_b(u_bc.seen_txen, ~(gb | mkb));
        chk_w(u_bc.mem[ptr], e);
        chk_w(u_bc.mem[ptr + 15'h0001], tag);
        chk_w(16'(u_bc.wr_cnt - w0), 16'h0002);
        reg_read(txmi_pkg::ADDR_LAST_WORD, rd);
        chk_w(rd, e);
        reg_read(txmi_pkg::ADDR_INT_STATUS, rd);
        chk_w(rd, {12'h000, ill, gb | mkb, e[10], 1'b1});
        chk_b(irq_q, mask_on);
        if (!mask_on) begin
            reg_write(txmi_pkg::ADDR_INT_MASK, 16'h000f);
            reg_read(txmi_pkg::ADDR_INT_MASK, rd);
            chk_w(rd, 16'h000f);
            chk_b(irq_q, 1'b1);
            mask_on = 1'b1;
        end
        reg_write(txmi_pkg::ADDR_INT_STATUS, 16'h000f);
        reg_read(txmi_pkg::ADDR_INT_STATUS, rd);
        chk_w(rd, 16'h0000);
        chk_b(irq_q, 1'b0);
    endtask : run_msg

    // Main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int a = 0; a < 16; a++) begin
            reg_read(a[3:0], rd);
            chk_w(rd, 16'h0000);
        end
        chk_b(irq_q, 1'b0);
        reg_write(4'h0, 16'hffff);
        reg_read(4'h0, rd);
        chk_w(rd, 16'h0000);
        mask_on = 1'b0;
        run_msg(0, 0, 5'h00, 0, 0, 0, 0, 0, 0, 0, 0, 15'h0500, 16'h1234);
        run_msg(0, 0, 5'h1f, 1, 1, 0, 0, 0, 0, 1, 0, 15'h0600, 16'h2345);
        run_msg(1, 0, 5'h03, 0, 1, 0, 0, 0, 0, 1, 0, 15'h0700, 16'h3456);
        run_msg(1, 0, 5'h0a, 1, 0, 0, 0, 0, 0, 0, 1, 15'h0800, 16'h4567);
        run_msg(0, 0, 5'h01, 0, 0, 1, 1, 0, 0, 0, 0, 15'h0900, 16'h5678);
        run_msg(0, 1, 5'h02, 1, 0, 0, 0, 1, 0, 0, 0, 15'h7ffe, 16'h6789);
        run_msg(0, 0, 5'h10, 0, 0, 0, 0, 1, 1, 0, 0, 15'h0a00, 16'h789a);
        run_msg(0, 0, 5'h04, 0, 0, 0, 0, 1, 0, 1, 0, 15'h0b00, 16'h89ab);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
